// *** rtl/gtim_top.v ***
// Sixteen-bit timer, two companion timers and carrier gated output
// What this block does
// - 16-bit main counter works as free timer, event counter or PWM base
// - Main counter steps on programmable prescale in free mode, bounded by period
// - Five independent channels each compare own 16-bit value
// - Each channel selects PWM output or capture of counter on edge
// - Carrier gated mode: main counter counts companion timer 0 periods
// - Carrier gated mode: output is channel 0 PWM AND companion timer 0 output
// - Companion timers have own prescale and 8-bit period
// - Each companion timer has one 8-bit compare channel
// - Companion channel drives a PWM output
`timescale 1ns/1ps
`include "gtim_consts.vh"
module gtim_top (
    input wire ref_clk,
    input wire reset,
    input wire mainEnable,
    input wire [1:0] mainMode,
    input wire [`GTIM_PRE_W-1:0] mainPrescale,
    input wire [`GTIM_MAIN_W-1:0] mainPeriod,
    input wire eventIn,
    input wire carrierGatedOutputMode,
    input wire [`GTIM_NCH-1:0] chCapture,
    input wire [2*`GTIM_NCH-1:0] chEdge,
    input wire [`GTIM_NCH*`GTIM_MAIN_W-1:0] chCompare,
    input wire [`GTIM_NCH-1:0] chIn,
    input wire [1:0] compEnable,
    input wire [2*`GTIM_PRE_W-1:0] compPrescale,
    input wire [2*`GTIM_COMP_W-1:0] compPeriod,
    input wire [2*`GTIM_COMP_W-1:0] compCompare,
    output reg [`GTIM_MAIN_W-1:0] mainCount_r,
    output reg [`GTIM_NCH-1:0] chPwm_r,
    output reg [`GTIM_NCH*`GTIM_MAIN_W-1:0] chCaptured_r,
    output reg [`GTIM_NCH-1:0] chCaptureFlag_r,
    output reg [1:0] compPwm_r,
    output reg [2*`GTIM_COMP_W-1:0] compCount_r,
    output reg irOut_r
);
    reg [`GTIM_PRE_W-1:0] preCnt_r;
    reg [2:0] evSync_r;
    reg evSeen_r;
    reg [`GTIM_NCH-1:0] chS1_r;
    reg [`GTIM_NCH-1:0] chS2_r;
    reg [`GTIM_NCH-1:0] chS3_r;
    reg [`GTIM_NCH-1:0] chSeen_r;
    wire [1:0] compDone;
    wire [1:0] compPwm;
    wire [2*`GTIM_COMP_W-1:0] compCount;
    wire preTick;
    wire evEdge;
    reg mainTick;
    integer i;

    function edgeHit;
        input [1:0] sel;
        input prev;
        input cur;
        begin
            case (sel)
                `GTIM_EDGE_RISE: edgeHit = !prev && cur;
                `GTIM_EDGE_FALL: edgeHit = prev && !cur;
                `GTIM_EDGE_BOTH: edgeHit = prev != cur;
                default: edgeHit = 1'b0;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1)
        begin : compGen
            gtim_comp_timer uComp (
                .ref_clk(ref_clk),
                .reset(reset),
                .enable(compEnable[g]),
                .prescale(compPrescale[g*`GTIM_PRE_W +: `GTIM_PRE_W]),
                .period(compPeriod[g*`GTIM_COMP_W +: `GTIM_COMP_W]),
                .compare(compCompare[g*`GTIM_COMP_W +: `GTIM_COMP_W]),
                .count_r(compCount[g*`GTIM_COMP_W +: `GTIM_COMP_W]),
                .pwmOut_r(compPwm[g]),
                .periodDone_r(compDone[g])
            );
        end
    endgenerate

    // Main prescaler tick
    assign preTick = preCnt_r == mainPrescale;
    // Stable event edge: stages two and three agree on a new high level
    assign evEdge = (evSync_r[1] == evSync_r[2]) && evSync_r[2] && !evSeen_r;

    // Source of main counter steps
    always @*
    begin
        mainTick = 1'b0;
        if (mainEnable)
        begin
            if (carrierGatedOutputMode)
                mainTick = compDone[0];
            else
            begin
                case (mainMode)
                    `GTIM_MODE_FREE: mainTick = preTick;
                    `GTIM_MODE_EVENT: mainTick = evEdge;
                    default: mainTick = 1'b0;
                endcase
            end
        end
    end

    // Event pin synchroniser
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            evSync_r <= `GTIM_ZERO3;
            evSeen_r <= 1'b0;
        end
        else
        begin
            evSync_r <= {evSync_r[1:0], eventIn};
            if (evSync_r[1] == evSync_r[2])
                evSeen_r <= evSync_r[2];
        end
    end

    // Main prescaler and counter
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            preCnt_r <= `GTIM_ZERO8;
            mainCount_r <= `GTIM_ZERO16;
        end
        else
        begin
            if (!mainEnable || preTick)
                preCnt_r <= `GTIM_ZERO8;
            else
                preCnt_r <= preCnt_r + `GTIM_ONE8;
            if (mainTick)
            begin
                if (mainCount_r >= mainPeriod)
                    mainCount_r <= `GTIM_ZERO16;
                else
                    mainCount_r <= mainCount_r + `GTIM_ONE16;
            end
        end
    end

    // Capture pin synchronisers
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            chS1_r <= `GTIM_ZERO5;
            chS2_r <= `GTIM_ZERO5;
            chS3_r <= `GTIM_ZERO5;
        end
        else
        begin
            chS1_r <= chIn;
            chS2_r <= chS1_r;
            chS3_r <= chS2_r;
        end
    end

    // Channels: compare for PWM or capture on edge
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            chSeen_r <= `GTIM_ZERO5;
            chPwm_r <= `GTIM_ZERO5;
            chCaptured_r <= {`GTIM_NCH{`GTIM_ZERO16}};
            chCaptureFlag_r <= `GTIM_ZERO5;
        end
        else
        begin
            for (i = 0; i < `GTIM_NCH; i = i + 1)
            begin
                chCaptureFlag_r[i] <= 1'b0;
                if (chS2_r[i] == chS3_r[i])
                    chSeen_r[i] <= chS3_r[i];
                if (chCapture[i])
                begin
                    chPwm_r[i] <= 1'b0;
                    if (chS2_r[i] == chS3_r[i] &&
                        edgeHit(chEdge[2*i +: 2], chSeen_r[i], chS3_r[i]))
                    begin
                        chCaptured_r[i*`GTIM_MAIN_W +: `GTIM_MAIN_W] <=
                            mainCount_r;
                        chCaptureFlag_r[i] <= 1'b1;
                    end
                end
                else
                    chPwm_r[i] <= mainEnable && (mainCount_r <
                        chCompare[i*`GTIM_MAIN_W +: `GTIM_MAIN_W]);
            end
        end
    end

    // Companion outputs and carrier gated output
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            compPwm_r <= `GTIM_ZERO2;
            compCount_r <= {2{`GTIM_ZERO8}};
            irOut_r <= 1'b0;
        end
        else
        begin
            compPwm_r <= compPwm;
            compCount_r <= compCount;
            irOut_r <= carrierGatedOutputMode && chPwm_r[0] &&
                compPwm[0];
        end
    end
endmodule // gtim_top

// *** include/gtim_consts.vh ***
// Constants for the general timer block with carrier gated output
`ifndef GTIM_CONSTS_VH
`define GTIM_CONSTS_VH
`define GTIM_MAIN_W 16
`define GTIM_COMP_W 8
`define GTIM_NCH 5
`define GTIM_PRE_W 8
`define GTIM_MODE_FREE 2'h0
`define GTIM_MODE_EVENT 2'h1
`define GTIM_MODE_STOP 2'h2
`define GTIM_EDGE_RISE 2'h1
`define GTIM_EDGE_FALL 2'h2
`define GTIM_EDGE_BOTH 2'h3
`define GTIM_ZERO16 16'h0000
`define GTIM_ZERO8 8'h00
`define GTIM_ZERO5 5'h00
`define GTIM_ZERO3 3'h0
`define GTIM_ZERO2 2'h0
`define GTIM_ONE8 8'h01
`define GTIM_ONE16 16'h0001
`endif

// *** rtl/gtim_comp_timer.v ***
// Eight-bit companion timer with one compare channel
`timescale 1ns/1ps
`include "gtim_consts.vh"
module gtim_comp_timer (
    input wire ref_clk,
    input wire reset,
    input wire enable,
    input wire [`GTIM_PRE_W-1:0] prescale,
    input wire [`GTIM_COMP_W-1:0] period,
    input wire [`GTIM_COMP_W-1:0] compare,
    output reg [`GTIM_COMP_W-1:0] count_r,
    output reg pwmOut_r,
    output reg periodDone_r
);
    reg [`GTIM_PRE_W-1:0] preCnt_r;
    wire tick;
    assign tick = enable && (preCnt_r == prescale);
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            preCnt_r <= `GTIM_ZERO8;
            count_r <= `GTIM_ZERO8;
            pwmOut_r <= 1'b0;
            periodDone_r <= 1'b0;
        end
        else
        begin
            periodDone_r <= 1'b0;
            if (!enable || tick)
                preCnt_r <= `GTIM_ZERO8;
            else
                preCnt_r <= preCnt_r + `GTIM_ONE8;
            if (tick)
            begin
                if (count_r >= period)
                begin
                    count_r <= `GTIM_ZERO8;
                    periodDone_r <= 1'b1;
                end
                else
                    count_r <= count_r + `GTIM_ONE8;
            end
            pwmOut_r <= enable && (count_r < compare);
        end
    end
endmodule // gtim_comp_timer

// *** verif/gtim_pin_model.sv ***
// Pin model toggling capture and event lines
`timescale 1ns/1ps
module gtim_pin_model (
    input wire ref_clk,
    input wire run,
    output logic [4:0] chIn,
    output logic eventIn
);
integer k = 0;
initial chIn = 5'h00;
assign eventIn = chIn[0];
always @(negedge ref_clk)
begin
    k <= run ? k + 1 : 0;
    if (run && k % 8 == 7)
        chIn <= ~chIn;
end
endmodule // gtim_pin_model

// *** verif/gtim_chk.sv ***
// Assertion checker for the general timer block
`timescale 1ns/1ps
module gtim_chk (
    input wire ref_clk,
    input wire reset,
    input wire [1:0] mainMode,
    input wire [15:0] mainPeriod,
    input wire carrierGatedOutputMode,
    input wire [4:0] chCapture,
    input wire [15:0] mainCount_r,
    input wire [4:0] chPwm_r,
    input wire [79:0] chCaptured_r,
    input wire [4:0] chCaptureFlag_r,
    input wire [1:0] compPwm_r,
    input wire irOut_r
);
default clocking @(posedge ref_clk); endclocking
default disable iff (reset);
a_count_step: assert property (
    $changed(mainCount_r) && mainCount_r != 0
    |-> mainCount_r == $past(mainCount_r) + 16'h0001) else $error("step");
a_period_wrap: assert property (
    $changed(mainCount_r) && $past(mainCount_r) >= $past(mainPeriod)
    |-> mainCount_r == 16'h0000) else $error("wrap");
a_stop_hold: assert property (
    !$past(reset) && $past(mainMode[1]) && !$past(carrierGatedOutputMode)
    |-> $stable(mainCount_r)) else $error("stop");
a_ir_mode: assert property (
    irOut_r |-> $past(carrierGatedOutputMode)) else $error("ir mode");
a_ir_and: assert property (
    irOut_r |-> chPwm_r[0] || $past(chPwm_r[0])) else $error("ir and");
a_ir_exact: assert property (
    irOut_r == ($past(carrierGatedOutputMode) && $past(chPwm_r[0])
    && compPwm_r[0])) else $error("ir gate");
a_flag_pulse: assert property (
    chCaptureFlag_r[2] |=> !chCaptureFlag_r[2]) else $error("flag");
a_cap_nopwm: assert property (
    $past(chCapture[1]) |-> !chPwm_r[1]) else $error("pwm in capture");
a_cap_hold: assert property (
    !$past(reset) && !chCaptureFlag_r[2] |-> $stable(chCaptured_r[47:32]))
    else $error("capture hold");
c_flag: cover property (chCaptureFlag_r[0]);
c_ir: cover property (irOut_r);
c_wrap: cover property ($fell(mainCount_r[0]) && mainCount_r == 0);
endmodule // gtim_chk
bind gtim_top gtim_chk i_gtim_chk (.*);

// *** verif/gtim_top_tb.sv ***
// Testbench for the general timer block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t mismatch %h %h", $time, a, b); end end
module gtim_top_tb;
logic ref_clk = 0, reset = 1, mainEnable = 0, cgm = 0, run = 0, p = 0;
logic [1:0] mainMode = 0, compEnable = 0, compPwm_r;
logic [7:0] mainPrescale = 0;
logic [15:0] mainPeriod = 0, compPrescale = 0, compPeriod = 0;
logic [15:0] compCompare = 0, mainCount_r, compCount_r;
logic [4:0] chCapture = 0, chIn, chPwm_r, chCaptureFlag_r;
logic [9:0] chEdge = 0;
logic [79:0] chCompare = 0, chCaptured_r;
logic eventIn, irOut_r;
integer seed = 32'h97aa, bad_count = 0, num_checks = 0;
integer pc = 0, cnt = 0, i, j, r = 0, f = 0, h = 0, n [0:4];
integer cp = 0, cc = 0, pw = 0, dn = 0, mc = 0, mo = 0, pp = 0, tk = 0;
integer pres = 0;
gtim_top i_gtim_top (.*, .carrierGatedOutputMode(cgm));
gtim_pin_model i_gtim_pin_model (.*);
task end_sim;
begin
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
end
endtask
initial forever #5 ref_clk = ~ref_clk;
initial n = '{0, 0, 0, 0, 0};
always @(negedge ref_clk)
begin
    if (chIn[0] != p)
        if (chIn[0]) r++; else f++;
    p = chIn[0];
    h += irOut_r;
    if (chCaptureFlag_r[0])
        `CHK(chCaptured_r[15:0], cnt[15:0] + n[0][15:0])
    for (j = 0; j < 5; j++)
        n[j] += chCaptureFlag_r[j];
end
initial
begin
    repeat (12) @(negedge ref_clk);
    mainPrescale = {$random(seed)} % 4;
    mainPeriod = {$random(seed)} % 40 + 3;
    chCompare[31:0] = $random(seed);
    mainEnable = 1;
    reset = 0;
    for (i = 0; i < 300; i++)
    begin
        @(negedge ref_clk);
        `CHK(chPwm_r[1:0], {cnt < chCompare[31:16], cnt < chCompare[15:0]})
        if (!mainMode[1] && pc == mainPrescale)
            cnt = cnt >= mainPeriod ? 0 : cnt + 1;
        if (!mainMode[1])
            pc = pc == mainPrescale ? 0 : pc + 1;
        `CHK(mainCount_r, cnt[15:0])
        if (i == 200)
            mainMode = 2;
    end
    $display("count test done");
    mainPeriod = 16'hFFFF;
    mainMode = 1;
    chCapture = 5'h1F;
    chEdge = 10'h139;
    run = 1;
    repeat (200) @(negedge ref_clk);
    run = 0;
    repeat (10) @(negedge ref_clk);
    `CHK(mainCount_r, cnt[15:0] + r[15:0])
    `CHK(n[0] == r && n[1] == f && n[2] == r + f, 1'b1)
    `CHK(n[3] == 0 && n[4] == r && r > 2, 1'b1)
    $display("capture test done");
    {mainMode, mainPeriod, chCapture, chCompare[15:0]} = {18'h4, 5'h0, 16'h2};
    {compEnable, compPeriod, compCompare} = {2'h3, 16'h0503, 16'h0202};
    compPrescale[7:0] = {$random(seed)} % 3;
    cgm = 1;
    mc = cnt + r;
    pp = chPwm_r[0];
    pres = compPrescale[7:0];
    repeat (300)
    begin
        @(negedge ref_clk);
        mo = mc;
        if (dn)
            mc = mc >= 4 ? 0 : mc + 1;
        `CHK(mainCount_r, mc[15:0])
        `CHK(chPwm_r[0], mo < 2)
        `CHK(compCount_r[7:0] <= 8'h03, 1'b1)
        `CHK(compCount_r[7:0], cc[7:0])
        `CHK(compPwm_r[0], pw[0])
        `CHK(irOut_r, pp[0] & compPwm_r[0])
        tk = cp == pres;
        dn = tk && cc >= 3;
        pw = cc < 2;
        if (tk)
            cc = cc >= 3 ? 0 : cc + 1;
        cp = tk ? 0 : cp + 1;
        pp = chPwm_r[0];
    end
    `CHK(h != 0 && mainCount_r <= 16'h0004, 1'b1)
    $display("carrier test done");
    end_sim;
end
endmodule // gtim_top_tb
